/* core/fcms_ctrl.sv */
// Host-side controller that sequences commands into a parallel boot-block flash
//
// Behaviour
// - Write FFh to leave any other mode; array reads then need no command.
// - Program is setup 40h or 10h, then one cycle with address and data.
// - Host holds program supply from data or confirm until ready bit reads 1.
// - After setup alone, a null write FFh or FFFFh cancels the program.
// - First cycle address is don't-care but host keeps address lines stable.
// - Erase is 20h at any address, then D0h at an address inside the block.
// - Code 00h and unlisted codes are invalid and never issued.
`timescale 1ns/1ps
`default_nettype none

module fcms_ctrl
    import fcms_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [31:0] reg_rdata_o,
    output logic      [17:0] fl_addr_o,
    input  wire logic [15:0] fl_dq_i,
    output logic      [15:0] fl_dq_o,
    output logic      [15:0] fl_dq_oe_n_o,
    output logic             chip_select_n_o,
    output logic             write_strobe_n_o,
    output logic             output_enable_n_o,
    output logic             deep_reset_n_o,
    output logic             width_select_o,
    output logic             boot_unlock_o,
    output logic             boost_en_o,
    output logic             program_supply_en_o
);

    typedef struct packed {
        fcms_bus_t  st;
        fcms_op_t   op;
        fcms_kind_t kind;
        logic [1:0]  idx;
        logic [7:0]  cnt;
        logic        again;
        fcms_mode_t  mode;
        logic [3:0]  cfg;
        logic [18:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [7:0]  fstat;
        logic        busy;
        logic        refused;
        logic        vpp;
        logic [17:0] a;
        logic [15:0] dq;
        logic [15:0] dq_oe_n;
        logic        cs_n;
        logic        we_n;
        logic        oe_n;
        logic        rst_n;
        logic [31:0] rd;
    } fcms_state_t;

    fcms_state_t s_q;
    fcms_state_t s_d;
    logic [15:0] dq_sync;
    logic        dq_stable;
    fcms_step_t  stp;

    // ------------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------------
    fcms_sync #(.W(16)) u_sync (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .d_i      (fl_dq_i),
        .q_o      (dq_sync),
        .stable_o (dq_stable)
    );

    // ------------------------------------------------------------------
    // Command sequences per operation
    // ------------------------------------------------------------------
    function automatic fcms_step_t step(input fcms_op_t op, input logic [1:0] i);
        fcms_step_t r;
        r = '{kind: K_END, cmd: 8'h00, arm: 1'b0};
        case (op)
            OP_ARRAY:   r = (i == 2'd0) ? '{K_CMD, CMD_ARRAY, 1'b0} : (i == 2'd1) ? '{K_READ, 8'h00, 1'b0} : r;
            OP_IDENT:   r = (i == 2'd0) ? '{K_CMD, CMD_IDENT, 1'b0} : (i == 2'd1) ? '{K_READ, 8'h00, 1'b0} : r;
            OP_STATUS:  r = (i == 2'd0) ? '{K_CMD, CMD_STATUS, 1'b0} : (i == 2'd1) ? '{K_READ, 8'h00, 1'b0} : r;
            OP_CLEAR:   r = (i == 2'd0) ? '{K_CMD, CMD_CLEAR, 1'b0} : r;
            OP_PROGRAM: r = (i == 2'd0) ? '{K_CMD, CMD_PROG, 1'b0} : (i == 2'd1) ? '{K_DATA, 8'h00, 1'b1} :
                            (i == 2'd2) ? '{K_POLL, 8'h00, 1'b0} : r;
            // setup, confirm in block, wait ready
            OP_ERASE:   r = (i == 2'd0) ? '{K_CMD, CMD_ERASE, 1'b0} : (i == 2'd1) ? '{K_CMD, CMD_CONFIRM, 1'b1} :
                            (i == 2'd2) ? '{K_POLL, 8'h00, 1'b0} : r;
            OP_SUSPEND: r = (i == 2'd0) ? '{K_CMD, CMD_SUSPEND, 1'b0} : (i == 2'd1) ? '{K_POLL, 8'h00, 1'b0} : r;
            // resume and wait for the erase to finish
            OP_RESUME:  r = (i == 2'd0) ? '{K_CMD, CMD_CONFIRM, 1'b1} : (i == 2'd1) ? '{K_POLL, 8'h00, 1'b0} : r;
            OP_CANCEL:  r = (i == 2'd0) ? '{K_CMD, CMD_PROG, 1'b0} : (i == 2'd1) ? '{K_NULL, 8'h00, 1'b0} : r;
            OP_RESET:   r = (i == 2'd0) ? '{K_RST, 8'h00, 1'b0} : r;
            default:    r = '{K_END, 8'h00, 1'b0};
        endcase
        return r;
    endfunction

    assign stp = step(s_q.op, s_q.idx);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Register writes; address and data freeze while busy
        if (reg_we_i) begin
            case (reg_addr_i)
                REG_CMD: begin
                    // unknown orders refused, so only listed codes reach the pins
                    if (s_q.busy || s_q.cfg[CFG_PDN] || reg_wdata_i[3:0] > 4'(OP_RESET)) begin
                        s_d.refused = 1'b1;
                    // no program or erase while supply error stands
                    end else if (s_q.fstat[SR_SUPPLY] &&
                                 (reg_wdata_i[3:0] == 4'(OP_PROGRAM) || reg_wdata_i[3:0] == 4'(OP_ERASE))) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.refused = 1'b0;
                        s_d.busy    = 1'b1;
                        s_d.op      = fcms_op_t'(reg_wdata_i[3:0]);
                        s_d.idx     = 2'd0;
                        s_d.st      = B_NEXT;
                    end
                end
                REG_ADDR:  s_d.addr  = s_q.busy ? s_q.addr : reg_wdata_i[18:0];
                REG_WDATA: s_d.wdata = s_q.busy ? s_q.wdata : reg_wdata_i[15:0];
                REG_CFG:   s_d.cfg   = reg_wdata_i[3:0];
                default:   s_d.cfg   = s_q.cfg;
            endcase
        end
        // Read data stands in the cycle after the strobe only
        s_d.rd = 32'h0000_0000;
        if (reg_re_i) begin
            case (reg_addr_i)
                REG_ADDR:  s_d.rd = {13'h0000, s_q.addr};
                REG_WDATA: s_d.rd = {16'h0000, s_q.wdata};
                REG_CFG:   s_d.rd = {28'h0000000, s_q.cfg};
                REG_STAT:  s_d.rd = {16'h0000, s_q.fstat, 4'h0, s_q.mode, s_q.refused, s_q.busy};
                REG_RDATA: s_d.rd = {16'h0000, s_q.rdata};
                default:   s_d.rd = 32'h0000_0000;
            endcase
        end
        // Address lines follow the address register in every cycle
        // stable address also in the first cycle
        s_d.a = s_q.cfg[CFG_WORD] ? s_q.addr[17:0] : s_q.addr[18:1];
        // Wait counter runs down to zero and rests there
        s_d.cnt = (s_q.cnt != 8'd0) ? s_q.cnt - 8'd1 : 8'd0;

        case (s_q.st)
            B_IDLE: begin
                // chip select high in idle gives standby
                s_d.cs_n  = 1'b1;
                s_d.rst_n = ~s_q.cfg[CFG_PDN];
                if (s_q.cfg[CFG_PDN]) begin
                    s_d.mode  = M_ARRAY;
                    s_d.fstat = FSTAT_RST;
                end
            end
            B_NEXT: begin
                s_d.kind = stp.kind;
                s_d.vpp  = s_q.vpp | stp.arm;
                s_d.cnt  = CYC_SET;
                case (stp.kind)
                    K_END: begin
                        s_d.busy = 1'b0;
                        s_d.st   = B_IDLE;
                    end
                    K_CMD, K_DATA, K_NULL: begin
                        // no array command when already in array read
                        if (stp.kind == K_CMD && stp.cmd == CMD_ARRAY && s_q.mode == M_ARRAY) begin
                            s_d.idx = s_q.idx + 2'd1;
                        end else begin
                            // byte mode: low lanes carry data
                            s_d.dq = (stp.kind == K_DATA) ? s_q.wdata :
                                     (stp.kind == K_NULL) ? NULL_WORD : {8'h00, stp.cmd};
                            s_d.dq_oe_n = s_q.cfg[CFG_WORD] ? 16'h0000 : 16'h7f00;
                            if (!s_q.cfg[CFG_WORD]) begin
                                s_d.dq[15] = s_q.addr[0];
                            end
                            s_d.cs_n = 1'b0;
                            s_d.st   = B_WSET;
                        end
                    end
                    K_READ, K_POLL: begin
                        // in byte mode the top data line still drives the lowest address bit
                        s_d.dq      = {s_q.addr[0], 15'h0000};
                        s_d.dq_oe_n = s_q.cfg[CFG_WORD] ? 16'hffff : 16'h7fff;
                        s_d.cs_n    = 1'b0;
                        s_d.oe_n    = 1'b0;
                        s_d.cnt     = CYC_ACC;
                        s_d.st      = B_RLOW;
                    end
                    K_RST: begin
                        // abort drops supply and pulses reset
                        s_d.rst_n = 1'b0;
                        s_d.vpp   = 1'b0;
                        s_d.cnt   = CYC_RP;
                        s_d.st    = B_RSTLOW;
                    end
                    default: s_d.st = B_IDLE;
                endcase
            end
            B_WSET: begin
                if (s_q.cnt == 8'd0) begin
                    s_d.we_n = 1'b0;
                    s_d.cnt  = CYC_WE;
                    s_d.st   = B_WLOW;
                end
            end
            B_WLOW: begin
                if (s_q.cnt == 8'd0) begin
                    s_d.we_n = 1'b1;
                    s_d.cnt  = CYC_REC;
                    s_d.st   = B_WREC;
                    // Track the flash mode from what was written
                    if (s_q.kind == K_NULL || s_q.dq[7:0] == CMD_ARRAY && s_q.kind == K_CMD) begin
                        s_d.mode = M_ARRAY;
                    end else if (s_q.kind == K_CMD && s_q.dq[7:0] == CMD_IDENT) begin
                        s_d.mode = M_IDENT;
                    end else if (!(s_q.kind == K_CMD && s_q.dq[7:0] == CMD_CLEAR)) begin
                        s_d.mode = M_STATUS;
                    end
                end
            end
            B_WREC, B_RREC: begin
                s_d.dq_oe_n = 16'hffff;
                s_d.cs_n    = 1'b1;
                s_d.oe_n    = 1'b1;
                if (s_q.cnt == 8'd0) begin
                    s_d.idx = s_q.again ? s_q.idx : s_q.idx + 2'd1;
                    s_d.again = 1'b0;
                    s_d.st  = B_NEXT;
                end
            end
            B_RLOW: begin
                if (s_q.cnt == 8'd0 && dq_stable) begin
                    s_d.rdata = s_q.cfg[CFG_WORD] ? dq_sync : {8'h00, dq_sync[7:0]};
                    if (s_q.mode == M_STATUS) begin
                        s_d.fstat = dq_sync[7:0];
                    end
                    // supply stays on until the ready bit reads one
                    if (s_q.kind == K_POLL && !dq_sync[SR_READY]) begin
                        s_d.again = 1'b1;
                    end else if (s_q.kind == K_POLL) begin
                        s_d.vpp = 1'b0;
                    end
                    // Toggling output enable refreshes latched status
                    s_d.oe_n = 1'b1;
                    s_d.cnt  = CYC_REC;
                    s_d.st   = B_RREC;
                end
            end
            B_RSTLOW: begin
                if (s_q.cnt == 8'd0) begin
                    s_d.rst_n = 1'b1;
                    s_d.cnt   = CYC_RWH;
                    s_d.st    = B_RSTWAIT;
                end
            end
            B_RSTWAIT: begin
                // flash back in array read with clear status
                s_d.mode  = M_ARRAY;
                s_d.fstat = FSTAT_RST;
                if (s_q.cnt == 8'd0) begin
                    s_d.idx = s_q.idx + 2'd1;
                    s_d.st  = B_NEXT;
                end
            end
            default: s_d.st = B_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q         <= '0;
            s_q.st      <= B_IDLE;
            s_q.mode    <= M_ARRAY;
            s_q.cfg     <= CFG_RST;
            s_q.addr    <= ADDR_RST;
            s_q.wdata   <= WDATA_RST;
            s_q.fstat   <= FSTAT_RST;
            s_q.dq_oe_n <= 16'hffff;
            s_q.cs_n    <= 1'b1;
            s_q.we_n    <= 1'b1;
            s_q.oe_n    <= 1'b1;
            s_q.rst_n   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_o         = s_q.rd;
    assign fl_addr_o           = s_q.a;
    assign fl_dq_o             = s_q.dq;
    assign fl_dq_oe_n_o        = s_q.dq_oe_n;
    assign chip_select_n_o     = s_q.cs_n;
    assign write_strobe_n_o    = s_q.we_n;
    assign output_enable_n_o   = s_q.oe_n;
    assign deep_reset_n_o      = s_q.rst_n;
    assign width_select_o      = s_q.cfg[CFG_WORD];
    // boot block unlock aids held from config
    assign boot_unlock_o       = s_q.cfg[CFG_UNLOCK];
    assign boost_en_o          = s_q.cfg[CFG_BOOST];
    assign program_supply_en_o = s_q.vpp;

endmodule

`default_nettype wire

/* core/fcms_sync.sv */
// Three-stage input synchroniser with an agreement flag
`timescale 1ns/1ps
`default_nettype none

module fcms_sync #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o,
    output logic              stable_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } fcms_sync_t;

    fcms_sync_t s_q;
    fcms_sync_t s_d;

    // Shift chain; first stage feeds only the second
    always_comb begin
        s_d    = s_q;
        s_d.s1 = d_i;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // A value counts once the second and third stages agree
    assign q_o      = s_q.s3;
    assign stable_o = (s_q.s2 == s_q.s3);

endmodule

`default_nettype wire

/* shared/fcms_pkg.sv */
// Constants and types for the flash command and mode sequencer controller
package fcms_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS    = 50;
    localparam int T_ACC_NS  = 80;    // Access time from select
    localparam int T_SET_NS  = 50;    // Address and data setup before strobe
    localparam int T_WE_NS   = 50;    // Write strobe low time
    localparam int T_REC_NS  = 50;    // Recovery between bus cycles
    localparam int T_RP_NS   = 150;   // Reset low pulse width
    localparam int T_RWH_NS  = 1000;  // Reset high to first access
    localparam int SYNC_DEPTH = 3;

    localparam logic [7:0] CYC_ACC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_DEPTH);
    localparam logic [7:0] CYC_SET = 8'((T_SET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CYC_WE  = 8'((T_WE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CYC_REC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CYC_RP  = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CYC_RWH = 8'((T_RWH_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------------
    // Flash command bytes
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_ARRAY   = 8'hff;
    localparam logic [7:0]  CMD_IDENT   = 8'h90;
    localparam logic [7:0]  CMD_STATUS  = 8'h70;
    localparam logic [7:0]  CMD_CLEAR   = 8'h50;
    localparam logic [7:0]  CMD_ERASE   = 8'h20;
    localparam logic [7:0]  CMD_CONFIRM = 8'hd0;
    localparam logic [7:0]  CMD_PROG    = 8'h40;
    localparam logic [7:0]  CMD_SUSPEND = 8'hb0;
    localparam logic [15:0] NULL_WORD   = 16'hffff;

    // Flash status bit positions
    localparam int SR_READY  = 7;
    localparam int SR_SUSP   = 6;
    localparam int SR_ERASE  = 5;
    localparam int SR_WRITE  = 4;
    localparam int SR_SUPPLY = 3;

    // ------------------------------------------------------------------
    // Controller registers (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD   = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CFG   = 8'h0c;
    localparam logic [7:0] REG_STAT  = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;

    localparam int CFG_WORD   = 0;
    localparam int CFG_UNLOCK = 1;
    localparam int CFG_BOOST  = 2;
    localparam int CFG_PDN    = 3;
    localparam logic [3:0]  CFG_RST   = 4'h0;
    localparam logic [18:0] ADDR_RST  = 19'h00000;
    localparam logic [15:0] WDATA_RST = 16'h0000;
    localparam logic [7:0]  FSTAT_RST = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ARRAY, OP_IDENT, OP_STATUS, OP_CLEAR, OP_PROGRAM,
        OP_ERASE, OP_SUSPEND, OP_RESUME, OP_CANCEL, OP_RESET
    } fcms_op_t;

    typedef enum logic [2:0] {
        K_END, K_CMD, K_DATA, K_NULL, K_READ, K_POLL, K_RST
    } fcms_kind_t;

    typedef enum logic [1:0] {M_ARRAY, M_IDENT, M_STATUS} fcms_mode_t;

    typedef enum logic [3:0] {
        B_IDLE, B_NEXT, B_WSET, B_WLOW, B_WREC, B_RLOW, B_RREC, B_RSTLOW, B_RSTWAIT
    } fcms_bus_t;

    typedef struct packed {
        fcms_kind_t kind;
        logic [7:0] cmd;
        logic       arm;   // Raise program supply from this cycle on
    } fcms_step_t;

endpackage

/* tb/fcms_ctrl_properties.sv */
// Pin-level checks bound to the flash controller
`timescale 1ns/1ps
`default_nettype none
module fcms_ctrl_properties (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [17:0] fl_addr_o,
    input wire logic [15:0] fl_dq_i,
    input wire logic [15:0] fl_dq_o,
    input wire logic [15:0] fl_dq_oe_n_o,
    input wire logic        chip_select_n_o,
    input wire logic        write_strobe_n_o,
    input wire logic        output_enable_n_o,
    input wire logic        deep_reset_n_o,
    input wire logic        width_select_o,
    input wire logic        program_supply_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // supply raised with the data or confirm cycle
    supply_rise_a: assert property ($rose(program_supply_en_o) |-> !chip_select_n_o) else $error("supply rose idle");
    // supply dropped only after a ready read
    ready_drop_a: assert property ($fell(program_supply_en_o) |-> $past(fl_dq_i[7], 2)) else $error("early drop");
    // write strobe low for two cycles, then released
    we_pulse_a: assert property ($fell(write_strobe_n_o) |=> !write_strobe_n_o ##1 write_strobe_n_o)
        else $error("strobe length");
    // address and data steady under the strobe
    addr_stable_a: assert property (!write_strobe_n_o |-> $stable(fl_addr_o) && $stable(fl_dq_o)) else $error("moved");
    // byte mode drives low lanes and top line only
    byte_lanes_a: assert property (!width_select_o && !write_strobe_n_o |-> fl_dq_oe_n_o == 16'h7f00) else $error("lanes");
    // lines released while the flash drives; byte mode keeps the top line as address
    read_float_a: assert property (!output_enable_n_o |-> &fl_dq_oe_n_o[14:0] && (fl_dq_oe_n_o[15] || !width_select_o))
        else $error("contention");
    pdn_idle_a: assert property (!deep_reset_n_o |-> chip_select_n_o && !program_supply_en_o) else $error("busy pdn");
    // reset pulse at least three cycles
    rst_pulse_a: assert property ($fell(deep_reset_n_o) |=> !deep_reset_n_o [*2]) else $error("short reset");
endmodule
bind fcms_ctrl fcms_ctrl_properties u_props (.clk_i(clk_i), .nrst_i(nrst_i), .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o), .chip_select_n_o(chip_select_n_o), .width_select_o(width_select_o),
    .write_strobe_n_o(write_strobe_n_o), .output_enable_n_o(output_enable_n_o), .deep_reset_n_o(deep_reset_n_o),
    .program_supply_en_o(program_supply_en_o));
`default_nettype wire

/* tb/fcms_ctrl_test.sv */
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module fcms_ctrl_test
    import fcms_pkg::*;
;
    typedef struct packed {logic [3:0] op; logic [18:0] adr; logic [15:0] wd;
                           logic chk; logic [15:0] rdx; logic [3:0] stx;} fcms_row_t;
    localparam logic [15:0] ID_MAK = 16'h00a5;  // Arbitrary value
    localparam logic [15:0] ID_DEV = 16'h005c;  // Arbitrary value
    // Program, read back, both codes, status, erase, cancel, read erased word
    localparam fcms_row_t ROWS [8] = '{
        '{4'h4, 19'h5, 16'h1234, 1'b0, 16'h0, 4'h8}, '{4'h0, 19'h5, 16'h0, 1'b1, 16'h1234, 4'h0},
        '{4'h1, 19'h1, 16'h0, 1'b1, ID_DEV, 4'h4}, '{4'h1, 19'h0, 16'h0, 1'b1, ID_MAK, 4'h4},
        '{4'h2, 19'h0, 16'h0, 1'b1, 16'h80, 4'h8}, '{4'h5, 19'h5, 16'h0, 1'b0, 16'h0, 4'h8},
        '{4'h8, 19'h5, 16'hffff, 1'b0, 16'h0, 4'h0}, '{4'h0, 19'h5, 16'h0, 1'b1, 16'hffff, 4'h0}};
    logic        clk_i = 1'b0, nrst_i = 1'b0, reg_we = 1'b0, reg_re = 1'b0, vpp_ok = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
    logic [17:0] fl_addr;
    logic [15:0] dq_out, dq_oe_n, dq_bus, fl_out;
    logic        cs_n, we_n, oe_n, rst_n, width, unlock, boost, vpp;
    int          n_fail = 0, compares = 0;
    fcms_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
        .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .fl_addr_o(fl_addr), .fl_dq_i(dq_bus), .fl_dq_o(dq_out),
        .fl_dq_oe_n_o(dq_oe_n), .chip_select_n_o(cs_n), .write_strobe_n_o(we_n), .output_enable_n_o(oe_n),
        .deep_reset_n_o(rst_n), .width_select_o(width), .boot_unlock_o(unlock), .boost_en_o(boost),
        .program_supply_en_o(vpp));
    fcms_flash_model #(.MAK(ID_MAK), .DEV(ID_DEV)) u_flash (.addr_i(fl_addr), .dq_i(dq_bus), .cs_n_i(cs_n),
        .we_n_i(we_n), .oe_n_i(oe_n), .rst_n_i(rst_n), .width_i(width), .vpp_i(vpp & vpp_ok), .dq_o(fl_out));
    // Each lane carries whichever side drives it
    assign dq_bus = (~dq_oe_n & dq_out) | (dq_oe_n & fl_out);
    initial forever #25 clk_i = ~clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin n_fail++; $display("[FAIL] %0t seen %h expected %h", $time, seen, exp); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
        @(posedge clk_i) reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i) {reg_addr, reg_re} <= {a, 1'b1};
        @(posedge clk_i) reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Issue an order, poll status until idle; bounded so a hang shows up
    task automatic op(input logic [3:0] c);
        wr(REG_CMD, {28'h0, c});
        for (int i = 0; i < 400; i++) begin rd(REG_STAT, rv); if (rv[0] === 1'b0) break; end
    endtask
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        wr(REG_CFG, 32'h1);
        foreach (ROWS[i]) begin
            wr(REG_ADDR, {13'h0, ROWS[i].adr});
            wr(REG_WDATA, {16'h0, ROWS[i].wd});
            op(ROWS[i].op);
            check(rv & 32'hf, {28'h0, ROWS[i].stx});
            if (ROWS[i].chk) rd(REG_RDATA, rv);
            if (ROWS[i].chk) check(rv, {16'h0, ROWS[i].rdx});
            $display("row %0d done", i);
        end
        // Second reset in mid-run, then array data with no command, byte mode
        @(posedge clk_i) nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 check({28'h0, rst_n, vpp, cs_n, we_n}, 32'h3);
        check(reg_rdata, 32'h0);
        @(posedge clk_i) nrst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        op(4'h0);
        rd(REG_RDATA, rv);
        check(rv & 32'hff, 32'hff);
        $display("reset done");
        // Missing supply, then refusal until the error bits are cleared
        vpp_ok <= 1'b0;
        op(4'h4);
        check(rv & 32'hff00, 32'h9800);
        op(4'h4);
        check(rv & 32'h2, 32'h2);
        vpp_ok <= 1'b1;
        op(4'h3);
        op(4'h2);
        rd(REG_RDATA, rv);
        check(rv & 32'hff, 32'h80);
        $display("supply fault done");
        wr(REG_CFG, 32'hf);
        repeat (5) @(posedge clk_i);
        #1 check({29'h0, rst_n, unlock, boost}, 32'h3);
        wr(REG_CFG, 32'h1);
        op(4'h9);
        check(rv & 32'hff0f, 32'h0);
        rd(8'h3c, rv);
        check(rv, 32'h0);
        $display("power and map done");
        conclude;
    end
    initial begin #2000000; n_fail++; conclude; end
endmodule
`default_nettype wire

/* tb/fcms_flash_model.sv */
// Behavioural boot-block flash for the controller bench
`timescale 1ns/1ps
`default_nettype none
module fcms_flash_model #(
    parameter logic [15:0] MAK = 16'h0011,  // Arbitrary value
    parameter logic [15:0] DEV = 16'h0022   // Arbitrary value
) (
    input  wire logic [17:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        rst_n_i,
    input  wire logic        width_i,
    input  wire logic        vpp_i,
    output logic      [15:0] dq_o
);
    logic [7:0]  st = 8'h80, p = 8'h00;
    logic [1:0]  md = 2'd0;
    logic [15:0] mem = 16'h0000, rd;
    logic        ers = 1'b0;
    int          tick = 0;
    // reset aborts work and clears status
    always @(negedge rst_n_i) {st, p, md} = {8'h80, 8'h00, 2'd0};
    // missing or faulted supply refuses the operation
    task automatic start(input logic er);
        md = 2'd2;
        if (!vpp_i || st[3]) st = st | (er ? 8'h28 : 8'h18);
        else begin st[7] = 1'b0; ers = er; tick = 0; if (!er) mem = dq_i; end
    endtask
    // busy ignores writes; second cycles finish setups
    always @(posedge we_n_i) if (rst_n_i && !cs_n_i && st[7]) begin
        if (p == 8'h40 || p == 8'h10) begin
            if (dq_i[7:0] != 8'hff || (width_i && dq_i[15:8] != 8'hff)) start(1'b0);
            else md = 2'd0;
        end else if (p == 8'h20) begin
            if (dq_i[7:0] == 8'hd0) start(1'b1);
            else {st[5:4], md} = 4'b1110;
        end else case (dq_i[7:0])
            8'hff: md = 2'd0;
            8'h90: md = 2'd1;
            8'h50: st[5:3] = 3'h0;
            default: md = 2'd2;
        endcase
        p = (p == 8'h00 && dq_i[7:0] inside {8'h40, 8'h10, 8'h20}) ? dq_i[7:0] : 8'h00;
    end
    // runs on whatever the select does, then reports ready
    always #250 if (!st[7] && ++tick == 4) begin st[7] = 1'b1; if (ers) mem = 16'hffff; end
    // status while busy or in status mode; released lines toggle
    always_comb rd = (!st[7] || md == 2'd2) ? {8'h00, st} : (md == 2'd1) ? (addr_i[0] ? DEV : MAK) : mem;
    assign dq_o = (!cs_n_i && !oe_n_i && rst_n_i) ? rd : ~rd;
endmodule
`default_nettype wire
